// ===== src/objmap_pkg.sv
// constants for the building network object map: object ids, codes,
// register offsets of the plain software port and reset values.
// assumes a single CORE_CLK domain.
package objmap_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // terminal selection codes for remote output
  localparam logic [7:0] SEL_REMOTE_POS = 8'h52;
  localparam logic [7:0] SEL_REMOTE_NEG = 8'hB6;
  localparam logic [7:0] SEL_RST = 8'h00;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_SEL_T1 = 8'h04;
  localparam logic [7:0] OFS_SEL_T2 = 8'h08;
  localparam logic [7:0] OFS_SEL_RA = 8'h0C;
  localparam logic [7:0] OFS_SEL_RB = 8'h10;
  localparam logic [7:0] OFS_BO_CMD = 8'h14;
  localparam logic [7:0] OFS_BV_CMD = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_INST_HI = 8'h20;
  localparam logic [7:0] OFS_INST_LO = 8'h24;
  localparam logic [7:0] OFS_INST = 8'h28;
  localparam logic [7:0] OFS_PORT = 8'h2C;
  localparam logic [7:0] OFS_ACK = 8'h30;
  // command object codes written to OFS_CMD
  localparam logic [1:0] KIND_BO = 2'h0;
  localparam logic [1:0] KIND_BV = 2'h1;
  localparam logic [1:0] KIND_NP = 2'h2;
  localparam logic [1:0] KIND_DEV = 2'h3;
  localparam logic [8:0] BV_FWD = 9'h12C;
  localparam logic [8:0] BV_REV = 9'h12D;
  localparam logic [8:0] BV_RUN = 9'h190;
  localparam logic [8:0] BV_DIR = 9'h191;
  localparam logic [8:0] BV_FRST = 9'h192;
  localparam logic [8:0] BO_T1 = 9'h000;
  localparam logic [8:0] BO_T2 = 9'h004;
  localparam logic [8:0] BO_RA = 9'h005;
  localparam logic [8:0] BO_RB = 9'h006;
  localparam logic [21:0] ID_WILDCARD = 22'h3FFFFF;
  localparam logic [21:0] INST_MAX = 22'h3FFFFE;
  localparam logic [21:0] INST_MULT = 22'h002710;
  // answer codes
  localparam logic [1:0] ACK_OK = 2'h0;
  localparam logic [1:0] ACK_DENIED = 2'h1;
  localparam logic [1:0] ACK_UNKNOWN = 2'h2;
  localparam logic [1:0] ACK_RANGE = 2'h3;
endpackage

// ===== src/objmap_if.sv
// carries the object-command stream and terminal selections between
// the object map and its terminal driver.
// assumes all signals change on CORE_CLK.
`timescale 1ns/100ps
interface objmap_if;
  logic [3:0] bo_cmd;
  logic [7:0] sel [4];
  logic [3:0] func_level;
  logic [3:0] pin_level;
  modport map (output bo_cmd, output sel, output func_level,
               input pin_level);
  modport drv (input bo_cmd, input sel, input func_level,
               output pin_level);
endinterface

// ===== src/term_drive.sv
// picks each output terminal's level from its remote command or its
// normal function, following the terminal's selection code.
// assumes selections and commands are registered upstream.
`timescale 1ns/100ps
module term_drive #(
  parameter bit NO_FUNC_VARIANT = 1'b0
) (
  input wire logic CORE_CLK, // clock
  input wire logic RST, // async reset, high
  objmap_if.drv bus // commands in, pin levels out
);
  logic [3:0] pin_ff;
  logic [3:0] nxt_pin;

  function automatic logic remote_sel(input logic [7:0] s);
    return (s == objmap_pkg::SEL_REMOTE_POS) ||
           (s == objmap_pkg::SEL_REMOTE_NEG);
  endfunction

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (remote_sel(bus.sel[i]))
        nxt_pin[i] = (bus.sel[i] == objmap_pkg::SEL_REMOTE_NEG) ?
                     !bus.bo_cmd[i] : bus.bo_cmd[i];
      else
        nxt_pin[i] = bus.func_level[i];
      if (NO_FUNC_VARIANT && i != 2)
        nxt_pin[i] = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      pin_ff <= 4'h0;
    else
      pin_ff <= nxt_pin;

  assign bus.pin_level = pin_ff;
endmodule

// ===== src/instance_calc.sv
// computes the device instance number from the upper and lower
// instance parameters and flags values outside the valid range.
// assumes inputs are stable registers; result is one cycle later.
`timescale 1ns/100ps
module instance_calc (
  input wire logic CORE_CLK, // clock
  input wire logic RST, // async reset, high
  input wire logic [15:0] upper_in, // upper instance parameter
  input wire logic [15:0] lower_in, // lower instance parameter
  output logic [21:0] inst_out, // instance number
  output logic valid_out // instance number in range
);
  logic [37:0] sum;
  logic [21:0] inst_ff;
  logic valid_ff;

  assign sum = 38'(upper_in) * 38'(objmap_pkg::INST_MULT) +
               38'(lower_in);

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      inst_ff <= 22'h000000;
      valid_ff <= 1'b1;
    end
    else
    begin
      inst_ff <= sum[21:0];
      valid_ff <= sum <= 38'(objmap_pkg::INST_MAX);
    end

  assign inst_out = inst_ff;
  assign valid_out = valid_ff;
endmodule

// ===== src/objmap_top.sv
// object map of the building network client: binary outputs, binary
// values, device instance and network port resolution, reached over
// a plain register port; drive status arrives on plain pins.
// assumes all inputs synchronous to CORE_CLK; read data one cycle late.
`timescale 1ns/100ps
// Overview of operation
// - remote output only with remote code
// - code 82 positive, 182 inverted
// - remote outputs ignore mode and sources
// - in-range commandable writes stored even denied
// - read-only run, ready, alarm, fault, reverse
// - objects 300/301 drive forward, reverse start
// - 400 start after speed scale applied, stop at once
// - 401 selects reverse or forward rotation
// - 402 clears fault without full reset
// - instance is upper times 10000 plus lower
// - port objects 0/1, wildcard read resolves arrival
// - variants hold outputs 0,4,6 low, remote or not
// - input status mirrors digital input terminals
module objmap_top #(
  parameter bit NO_FUNC_VARIANT = 1'b0
) (
  input wire logic CORE_CLK, // clock, 250 MHz
  input wire logic RST, // async reset, high
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [31:0] RDATA, // read data, cycle after RD
  input wire logic [3:0] FUNC_LEVEL, // normal terminal functions
  input wire logic RUNNING, // drive running
  input wire logic READY, // operation ready
  input wire logic ALARM, // minor alarm
  input wire logic FAULT, // fault active
  input wire logic REVERSE, // running in reverse
  input wire logic DIGITAL_INPUT_ZERO, // input terminal 0
  input wire logic DIGITAL_INPUT_ONE, // input terminal 1
  input wire logic MODE_OK, // operating mode allows writes
  input wire logic SCALE_APPLIED, // speed scale has been applied
  input wire logic ARRIVAL_PORT, // port of current request
  output logic [3:0] TERMINAL_OUT, // output terminal levels
  output logic FORWARD_START_INPUT, // forward start
  output logic REVERSE_START_INPUT, // reverse start
  output logic RUN_CMD, // start command
  output logic REVERSE_ROT, // reverse rotation request
  output logic FAULT_RELEASE, // one-cycle fault release
  output logic FAULT_FLAG // fault output status
);
  objmap_if link ();

  logic [7:0] sel_ff [4];
  logic [3:0] bo_ff;
  logic fwd_ff, rev_ff, run_req_ff, run_ff, dir_ff;
  logic frel_ff, fflag_ff;
  logic [15:0] upper_ff, lower_ff;
  logic [1:0] ack_ff;
  logic [1:0] port_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [21:0] inst;
  logic inst_ok;
  logic [3:0] pins_ff;

  // command word: [31:30] kind, [29] read service, [28] value,
  // [21:0] object identifier
  logic [1:0] kind;
  logic [21:0] obj;
  logic val_bit, rd_svc, cmd_wr, in_range, known;
  assign kind = WDATA[31:30];
  assign rd_svc = WDATA[29];
  assign val_bit = WDATA[28];
  assign obj = WDATA[21:0];
  assign in_range = WDATA[27:23] == 5'h00;
  assign cmd_wr = WR && ADDR == objmap_pkg::OFS_CMD;

  function automatic logic is_obj(input logic [21:0] o,
                                  input logic [8:0] id);
    return o == {13'h0000, id};
  endfunction

  always_comb
  begin
    known = 1'b0;
    case (kind)
      objmap_pkg::KIND_BO:
        known = is_obj(obj, objmap_pkg::BO_T1) ||
                is_obj(obj, objmap_pkg::BO_T2) ||
                is_obj(obj, objmap_pkg::BO_RA) ||
                is_obj(obj, objmap_pkg::BO_RB);
      objmap_pkg::KIND_BV:
        known = is_obj(obj, objmap_pkg::BV_FWD) ||
                is_obj(obj, objmap_pkg::BV_REV) ||
                is_obj(obj, objmap_pkg::BV_RUN) ||
                is_obj(obj, objmap_pkg::BV_DIR) ||
                is_obj(obj, objmap_pkg::BV_FRST);
      default:
        known = 1'b0;
    endcase
  end

  // terminal selections
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      for (int i = 0; i < 4; i++)
        sel_ff[i] <= objmap_pkg::SEL_RST;
    end
    else if (WR)
    begin
      case (ADDR)
        objmap_pkg::OFS_SEL_T1: sel_ff[0] <= WDATA[7:0];
        objmap_pkg::OFS_SEL_T2: sel_ff[1] <= WDATA[7:0];
        objmap_pkg::OFS_SEL_RA: sel_ff[2] <= WDATA[7:0];
        objmap_pkg::OFS_SEL_RB: sel_ff[3] <= WDATA[7:0];
        default: ;
      endcase
    end

  // binary output commands; no mode check on outputs
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      bo_ff <= 4'h0;
    else if (cmd_wr && kind == objmap_pkg::KIND_BO && in_range &&
             !rd_svc)
    begin
      if (is_obj(obj, objmap_pkg::BO_T1))
        bo_ff[0] <= val_bit;
      if (is_obj(obj, objmap_pkg::BO_T2))
        bo_ff[1] <= val_bit;
      if (is_obj(obj, objmap_pkg::BO_RA))
        bo_ff[2] <= val_bit;
      if (is_obj(obj, objmap_pkg::BO_RB))
        bo_ff[3] <= val_bit;
    end
    else if (WR && ADDR == objmap_pkg::OFS_BO_CMD)
      bo_ff <= WDATA[3:0];

  // binary value commands, stored even when mode denies the write
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      fwd_ff <= 1'b0;
      rev_ff <= 1'b0;
      run_req_ff <= 1'b0;
      dir_ff <= 1'b0;
    end
    else if (cmd_wr && kind == objmap_pkg::KIND_BV && in_range &&
             !rd_svc)
    begin
      if (is_obj(obj, objmap_pkg::BV_FWD))
        fwd_ff <= val_bit;
      if (is_obj(obj, objmap_pkg::BV_REV))
        rev_ff <= val_bit;
      if (is_obj(obj, objmap_pkg::BV_RUN))
        run_req_ff <= val_bit;
      if (is_obj(obj, objmap_pkg::BV_DIR))
        dir_ff <= val_bit;
    end
    else if (WR && ADDR == objmap_pkg::OFS_BV_CMD)
    begin
      fwd_ff <= WDATA[0];
      rev_ff <= WDATA[1];
      run_req_ff <= WDATA[2];
      dir_ff <= WDATA[3];
    end

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      run_ff <= 1'b0;
    else if (!run_req_ff)
      run_ff <= 1'b0;
    else if (SCALE_APPLIED)
      run_ff <= 1'b1;

  // fault status latches a drive fault; a release pulse clears it until
  // the drive raises a new fault, and the clear wins over a new fault
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      frel_ff <= 1'b0;
      fflag_ff <= 1'b0;
    end
    else
    begin
      frel_ff <= cmd_wr && kind == objmap_pkg::KIND_BV && !rd_svc &&
                 is_obj(obj, objmap_pkg::BV_FRST);
      if (FAULT && !fflag_ff && !frel_ff)
        fflag_ff <= 1'b1;
      else if (frel_ff)
        fflag_ff <= 1'b0;
    end

  // instance parameters
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      upper_ff <= 16'h0000;
      lower_ff <= 16'h0000;
    end
    else if (WR && ADDR == objmap_pkg::OFS_INST_HI)
      upper_ff <= WDATA[15:0];
    else if (WR && ADDR == objmap_pkg::OFS_INST_LO)
      lower_ff <= WDATA[15:0];

  instance_calc u_inst (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .upper_in(upper_ff),
    .lower_in(lower_ff),
    .inst_out(inst),
    .valid_out(inst_ok)
  );

  // answer code and network port resolution of the last command
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      ack_ff <= objmap_pkg::ACK_OK;
      port_ff <= 2'h0;
    end
    else if (cmd_wr)
    begin
      if ((kind == objmap_pkg::KIND_NP || kind == objmap_pkg::KIND_DEV)
          && obj == objmap_pkg::ID_WILDCARD && !rd_svc)
        ack_ff <= objmap_pkg::ACK_UNKNOWN;
      else if (kind == objmap_pkg::KIND_NP)
      begin
        if (obj == objmap_pkg::ID_WILDCARD)
        begin
          port_ff <= {1'b1, ARRIVAL_PORT};
          ack_ff <= objmap_pkg::ACK_OK;
        end
        else if (obj[21:1] == 21'h000000)
        begin
          port_ff <= {1'b1, obj[0]};
          ack_ff <= objmap_pkg::ACK_OK;
        end
        else
          ack_ff <= objmap_pkg::ACK_UNKNOWN;
      end
      else if (kind == objmap_pkg::KIND_DEV)
        ack_ff <= (obj == objmap_pkg::ID_WILDCARD || obj == inst) ?
                  objmap_pkg::ACK_OK : objmap_pkg::ACK_UNKNOWN;
      else if (!known)
        ack_ff <= objmap_pkg::ACK_UNKNOWN;
      else if (!in_range)
        ack_ff <= objmap_pkg::ACK_RANGE;
      else if (kind == objmap_pkg::KIND_BV && !MODE_OK && !rd_svc)
        ack_ff <= objmap_pkg::ACK_DENIED;
      else
        ack_ff <= objmap_pkg::ACK_OK;
    end

  assign link.bo_cmd = bo_ff;
  assign link.sel = sel_ff;
  assign link.func_level = FUNC_LEVEL;

  term_drive #(
    .NO_FUNC_VARIANT(NO_FUNC_VARIANT)
  ) u_drv (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .bus(link.drv)
  );

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      pins_ff <= 4'h0;
    else
      pins_ff <= link.pin_level;

  // read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    case (ADDR)
      objmap_pkg::OFS_SEL_T1: nxt_rdata = {24'h000000, sel_ff[0]};
      objmap_pkg::OFS_SEL_T2: nxt_rdata = {24'h000000, sel_ff[1]};
      objmap_pkg::OFS_SEL_RA: nxt_rdata = {24'h000000, sel_ff[2]};
      objmap_pkg::OFS_SEL_RB: nxt_rdata = {24'h000000, sel_ff[3]};
      objmap_pkg::OFS_BO_CMD: nxt_rdata = {28'h0000000, bo_ff};
      objmap_pkg::OFS_BV_CMD:
        nxt_rdata = {28'h0000000, dir_ff, run_req_ff, rev_ff, fwd_ff};
      objmap_pkg::OFS_STATUS:
        nxt_rdata = {20'h00000, pins_ff, 1'b0, DIGITAL_INPUT_ONE,
                     DIGITAL_INPUT_ZERO, REVERSE, fflag_ff, ALARM,
                     READY, RUNNING};
      objmap_pkg::OFS_INST_HI: nxt_rdata = {16'h0000, upper_ff};
      objmap_pkg::OFS_INST_LO: nxt_rdata = {16'h0000, lower_ff};
      objmap_pkg::OFS_INST: nxt_rdata = {9'h000, inst_ok, inst};
      objmap_pkg::OFS_PORT: nxt_rdata = {30'h00000000, port_ff};
      objmap_pkg::OFS_ACK: nxt_rdata = {30'h00000000, ack_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
      rdata_ff <= 32'h00000000;
    else if (RD)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 32'h00000000;

  assign RDATA = rdata_ff;
  assign TERMINAL_OUT = pins_ff;
  assign FORWARD_START_INPUT = fwd_ff;
  assign REVERSE_START_INPUT = rev_ff;
  assign RUN_CMD = run_ff;
  assign REVERSE_ROT = dir_ff;
  assign FAULT_RELEASE = frel_ff;
  assign FAULT_FLAG = fflag_ff;
endmodule

// ===== tb/objmap_monitor.sv
// checker for the object map top: command objects and drive status.
// assumes one CORE_CLK domain; attached to the top by bind.
`timescale 1ns/100ps
module objmap_monitor (
  input wire logic CORE_CLK, // clock
  input wire logic RST, // async reset, high
  input wire logic [7:0] ADDR, // byte address
  input wire logic [31:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  input wire logic [31:0] RDATA, // read data
  input wire logic RUNNING, // running
  input wire logic READY, // ready
  input wire logic ALARM, // minor alarm
  input wire logic REVERSE, // reverse running
  input wire logic FAULT, // fault
  input wire logic DIGITAL_INPUT_ZERO, // input 0
  input wire logic DIGITAL_INPUT_ONE, // input 1
  input wire logic SCALE_APPLIED, // scale applied
  input wire logic FORWARD_START_INPUT, // forward start
  input wire logic REVERSE_START_INPUT, // reverse start
  input wire logic RUN_CMD, // start command
  input wire logic REVERSE_ROT, // reverse request
  input wire logic FAULT_RELEASE, // release pulse
  input wire logic FAULT_FLAG // fault status
);
  logic bv_wr;
  logic rel_wr;
  logic [6:0] stat;
  // only in-range writes of the live service change stored values; the fault release ignores the range
  assign bv_wr = WR && ADDR == objmap_pkg::OFS_CMD &&
    WDATA[31:29] == {objmap_pkg::KIND_BV, 1'b0} && WDATA[27:23] == 5'h00;
  assign rel_wr = bv_wr && WDATA[21:0] == {13'h0000, objmap_pkg::BV_FRST};
  assign stat = {DIGITAL_INPUT_ONE, DIGITAL_INPUT_ZERO, REVERSE,
    FAULT_FLAG, ALARM, READY, RUNNING};
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  sequence bv_on(logic [8:0] id);
    bv_wr && WDATA[21:0] == {13'h0000, id};
  endsequence
  sequence release_seq;
    FAULT_RELEASE ##1 (!FAULT_RELEASE && !FAULT_FLAG);
  endsequence
  chk_rdata_idle: assert property (!RD |=> RDATA == 32'h00000000)
    else $error("read data not zero outside read answer");
  chk_fwd_start: assert property
    (bv_on(objmap_pkg::BV_FWD) |=> FORWARD_START_INPUT == $past(WDATA[28]))
    else $error("forward start does not follow write");
  chk_rev_start: assert property
    (bv_on(objmap_pkg::BV_REV) |=> REVERSE_START_INPUT == $past(WDATA[28]))
    else $error("reverse start does not follow write");
  chk_dir_select: assert property
    (bv_on(objmap_pkg::BV_DIR) |=> REVERSE_ROT == $past(WDATA[28]))
    else $error("rotation request does not follow write");
  chk_run_gate: assert property
    ($rose(RUN_CMD) |-> $past(SCALE_APPLIED))
    else $error("start issued before speed scale");
  // the request clears at the write edge, the start one edge later
  chk_run_stop: assert property
    (bv_on(objmap_pkg::BV_RUN) ##0 !WDATA[28] |=> ##1 !RUN_CMD)
    else $error("stop write left start active");
  chk_fault_clear: assert property
    (bv_on(objmap_pkg::BV_FRST) |=> release_seq)
    else $error("fault reset did not release");
  chk_flag_hold: assert property
    (FAULT_FLAG && !FAULT_RELEASE |=> FAULT_FLAG)
    else $error("fault flag dropped without release");
  chk_flag_set: assert property
    (!FAULT_FLAG && FAULT && !FAULT_RELEASE && !rel_wr |=> FAULT_FLAG)
    else $error("fault flag not set");
  chk_status_read: assert property
    (RD && ADDR == objmap_pkg::OFS_STATUS && $stable(stat)
     |=> RDATA[6:0] == $past(stat))
    else $error("status read mismatch");
endmodule

bind objmap_top objmap_monitor mon (
  .CORE_CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RUNNING, .READY,
  .ALARM, .REVERSE, .FAULT, .DIGITAL_INPUT_ZERO, .DIGITAL_INPUT_ONE,
  .SCALE_APPLIED, .FORWARD_START_INPUT, .REVERSE_START_INPUT, .RUN_CMD,
  .REVERSE_ROT, .FAULT_RELEASE, .FAULT_FLAG
);

// ===== tb/net_client.sv
// remote client model: issues reads and writes on the register port.
// assumes the port never stalls and read data stand one cycle.
`timescale 1ns/100ps
module net_client (
  input wire logic clk, // core clock
  output logic [7:0] addr, // byte address
  output logic [31:0] wdata, // write data
  output logic wr, // write strobe
  output logic rd, // read strobe
  input wire logic [31:0] rdata // read data
);
  initial
  begin
    addr = 8'h00;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // released lines show the inverse so stale values cannot pass
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule

// ===== tb/building_net_object_map_test.sv
// bench for the object map: client model, status pins, reference.
// assumes one 250 MHz clock and a registered read port.
`timescale 1ns/100ps
module building_net_object_map_test;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR;
  logic [31:0] WDATA, RDATA, d;
  logic WR, RD;
  logic [3:0] TERMINAL_OUT_X;
  logic [3:0] FUNC_LEVEL = 4'h0;
  logic [3:0] TERMINAL_OUT;
  logic RUNNING = 1'b0, READY = 1'b0, ALARM = 1'b0, FAULT = 1'b0;
  logic REVERSE = 1'b0, DIGITAL_INPUT_ZERO = 1'b0, DIGITAL_INPUT_ONE = 1'b0;
  logic MODE_OK = 1'b1, SCALE_APPLIED = 1'b0, ARRIVAL_PORT = 1'b0;
  logic FORWARD_START_INPUT, REVERSE_START_INPUT, RUN_CMD, REVERSE_ROT;
  logic FAULT_RELEASE, FAULT_FLAG;
  logic [15:0] seed = 16'h96CB;
  logic [7:0] code [3] = '{8'h52, 8'hB6, 8'h07};
  int boid [4] = '{0, 4, 5, 6};
  int bvid [3] = '{300, 301, 401};
  int bv [3] = '{0, 0, 0};
  int error_cnt = 0, n_compared = 0, exp, u, l;
  always #2 CORE_CLK = ~CORE_CLK;
  objmap_top #(.NO_FUNC_VARIANT(1'b0)) uut (.CORE_CLK, .RST, .ADDR,
    .WDATA, .WR, .RD, .RDATA, .FUNC_LEVEL, .RUNNING, .READY, .ALARM,
    .FAULT, .REVERSE, .DIGITAL_INPUT_ZERO, .DIGITAL_INPUT_ONE, .MODE_OK,
    .SCALE_APPLIED, .ARRIVAL_PORT, .TERMINAL_OUT, .FORWARD_START_INPUT,
    .REVERSE_START_INPUT, .RUN_CMD, .REVERSE_ROT, .FAULT_RELEASE,
    .FAULT_FLAG);
  net_client cli (.clk(CORE_CLK), .addr(ADDR), .wdata(WDATA), .wr(WR),
    .rd(RD), .rdata(RDATA));
  // second copy as the variant whose outputs 0, 4 and 6 have no function
  objmap_top #(.NO_FUNC_VARIANT(1'b1)) uut_variant (.CORE_CLK, .RST,
    .ADDR, .WDATA, .WR, .RD, .RDATA(), .FUNC_LEVEL, .RUNNING, .READY,
    .ALARM, .FAULT, .REVERSE, .DIGITAL_INPUT_ZERO, .DIGITAL_INPUT_ONE,
    .MODE_OK, .SCALE_APPLIED, .ARRIVAL_PORT,
    .TERMINAL_OUT(TERMINAL_OUT_X), .FORWARD_START_INPUT(),
    .REVERSE_START_INPUT(), .RUN_CMD(), .REVERSE_ROT(),
    .FAULT_RELEASE(), .FAULT_FLAG());
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] obj(input logic [1:0] k,
    input logic s, v, input logic [21:0] id);
    return {k, s, v, 6'h00, id};
  endfunction
  task automatic check(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
  task automatic settle(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    error_cnt++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge CORE_CLK);
    RST <= 1'b0;
    cli.get(objmap_pkg::OFS_SEL_T1, d);
    `CHK("select reset", 0, d);
    `CHK("outputs reset", 0, {TERMINAL_OUT, RUN_CMD, FAULT_FLAG});
    cli.get(8'hFC, d);
    `CHK("unmapped", 0, d);
    for (int t = 0; t < 4; t++)
      for (int c = 0; c < 3; c++)
        for (int v = 0; v < 2; v++)
        begin
          seed = lfsr(seed);
          MODE_OK <= seed[0];
          FUNC_LEVEL <= seed[4:1];
          cli.put(objmap_pkg::OFS_SEL_T1 + 8'(4 * t), {24'h000000, code[c]});
          cli.put(objmap_pkg::OFS_CMD, obj(2'h0, 1'b0, v[0], 22'(boid[t])));
          settle(3);
          exp = code[c] == 8'h52 ? v :
            code[c] == 8'hB6 ? 1 - v : FUNC_LEVEL[t];
          `CHK("terminal", exp, TERMINAL_OUT[t]);
          `CHK("variant terminal", t == 2 ? exp : 0,
            TERMINAL_OUT_X[t]);
          cli.get(objmap_pkg::OFS_BO_CMD, d);
          `CHK("stored command", v, d[t]);
        end
    for (int i = 0; i < 6; i++)
    begin
      MODE_OK <= i[0];
      bv[i % 3] = i < 3;
      cli.put(objmap_pkg::OFS_CMD, obj(2'h1, 1'b0, i < 3, 22'(bvid[i % 3])));
      `CHK("value outs", {bv[2][0], bv[1][0], bv[0][0]},
        {REVERSE_ROT, REVERSE_START_INPUT, FORWARD_START_INPUT});
      cli.get(objmap_pkg::OFS_ACK, d);
      `CHK("value ack", !i[0], d[1:0]);
    end
    cli.put(objmap_pkg::OFS_CMD, obj(2'h1, 1'b0, 1'b1, 22'd400));
    settle(2);
    `CHK("run before scale", 0, RUN_CMD);
    SCALE_APPLIED <= 1'b1;
    settle(2);
    `CHK("run", 1, RUN_CMD);
    cli.put(objmap_pkg::OFS_CMD, obj(2'h1, 1'b0, 1'b0, 22'd400));
    // the start drops one edge after the stored request clears
    settle(1);
    `CHK("stop", 0, RUN_CMD);
    FAULT <= 1'b1;
    settle(2);
    FAULT <= 1'b0;
    settle(2);
    `CHK("fault held", 1, FAULT_FLAG);
    cli.put(objmap_pkg::OFS_CMD, obj(2'h1, 1'b0, 1'b1, 22'd402));
    `CHK("release", 1, FAULT_RELEASE);
    settle(1);
    `CHK("fault cleared", 0, FAULT_FLAG);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      {DIGITAL_INPUT_ONE, DIGITAL_INPUT_ZERO, REVERSE, ALARM, READY,
        RUNNING} <= seed[5:0];
      settle(1);
      cli.get(objmap_pkg::OFS_STATUS, d);
      `CHK("status", {seed[5:3], 1'b0, seed[2:0]}, d[6:0]);
    end
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      u = i == 2 ? seed % 420 : 419;
      l = i == 0 ? 4302 : i == 1 ? 4303 : seed % 10000;
      cli.put(objmap_pkg::OFS_INST_HI, 32'(u));
      cli.put(objmap_pkg::OFS_INST_LO, 32'(l));
      cli.get(objmap_pkg::OFS_INST, d);
      exp = u * 10000 + l;
      `CHK("instance", exp % 4194304, d[21:0]);
      `CHK("instance valid", exp <= 4194302, d[22]);
      // device object answers to the computed instance, or to the wildcard with the read service, only
      cli.put(objmap_pkg::OFS_CMD, obj(2'h3, 1'b1, 1'b0, 22'(exp - i % 2)));
      cli.get(objmap_pkg::OFS_ACK, d);
      `CHK("device id", i == 1 ? 2 : 0, d[1:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      ARRIVAL_PORT <= i[0];
      // wildcard used with the read service
      cli.put(objmap_pkg::OFS_CMD,
        obj(2'h2, 1'b1, 1'b0, i < 2 ? 22'h3FFFFF : 22'(i - 2)));
      cli.get(objmap_pkg::OFS_PORT, d);
      `CHK("port", 2 + i % 2, d[1:0]);
    end
    for (int k = 2; k < 4; k++)
    begin
      cli.put(objmap_pkg::OFS_CMD, obj(2'(k), 1'b0, 1'b0, 22'h3FFFFF));
      cli.get(objmap_pkg::OFS_ACK, d);
      `CHK("wildcard write", 2, d[1:0]);
    end
    // out-of-range value must not be stored
    cli.put(objmap_pkg::OFS_CMD,
      obj(2'h1, 1'b0, 1'b1, 22'd300) | 32'h08000000);
    `CHK("range drop", 0, FORWARD_START_INPUT);
    cli.get(objmap_pkg::OFS_ACK, d);
    `CHK("range ack", 3, d[1:0]);
    conclude();
  end
endmodule
